// >>> design/pdstc_top.sv
// power-down and self-test pin control top
`timescale 1ns/1ps
module pdstc_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // control pins from host
  input wire logic power_down_n_input_i,
  input wire logic self_test_enable_pin_i,
  input wire logic self_test_clock_select_pin_i,
  // role select from register file
  input wire logic spi_role_sel_i,
  // spi side of shared pins
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_n_i,
  // fast gpio side of shared pins
  input wire logic [3:0] fast_gpio_out_i,
  input wire logic [3:0] fast_gpio_oe_n_i,
  // shared pin pads
  input wire logic [3:0] pad_in_i,
  output logic [3:0] pad_out_o,
  output logic [3:0] pad_oe_n_o,
  // pad inputs routed back to core
  output logic [3:0] spi_in_o,
  output logic [3:0] fast_gpio_in_o,
  // power and mode status
  output logic core_rst_n_o,
  output logic pll_en_o,
  output logic powered_o,
  output logic self_test_mode_o,
  output logic test_clk_sel_o,
  output logic external_interrupt_input_o
);
  typedef struct packed {
    pdstc_pkg::pdstc_pwr_t pwr;
    logic core_rst_n;
    logic pll_en;
    logic powered;
    logic st_mode;
    logic clk_sel;
    logic irq_in;
    pdstc_pkg::pdstc_pad_t pad;
    logic [3:0] spi_in;
    logic [3:0] gpio_in;
  } pdstc_st_t;

  pdstc_st_t st_q, st_d;
  pdstc_pkg::pdstc_pins_t pins;
  logic [2:0] pins_raw;
  logic [2:0] pins_sync;
  logic [3:0] pad_sync;

  // pad supplies the pull-down, so an open pin arrives here as 0
  assign pins_raw = {power_down_n_input_i, self_test_enable_pin_i, self_test_clock_select_pin_i};
  assign pins = pins_sync;

  pdstc_sync #(.W(3)) u_pin_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  pdstc_sync #(.W(4)) u_pad_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(pad_in_i),
    .sync_o(pad_sync)
  );

  // the four shared pads follow one owner as a group
  function automatic logic [3:0] pdstc_pick(
    input logic spi_role,
    input logic [3:0] spi_v,
    input logic [3:0] gpio_v
  );
    if (spi_role == pdstc_pkg::PDSTC_ROLE_SPI) begin
      return spi_v;
    end
    return gpio_v;
  endfunction

  // pad levels reach only the owner; the idle side reads zeros,
  // so a role change never hands stale levels to the other engine
  function automatic logic [3:0] pdstc_route(
    input logic powered,
    input logic spi_role,
    input logic owner,
    input logic [3:0] pad_v
  );
    if (powered && (spi_role == owner)) begin
      return pad_v;
    end
    return pdstc_pkg::PDSTC_FGPIO_RST;
  endfunction

  // pad view while the core is held: released, driving nothing
  function automatic pdstc_pkg::pdstc_pad_t pdstc_pad_idle();
    pdstc_pkg::pdstc_pad_t p;
    p.out = pdstc_pkg::PDSTC_FGPIO_RST;
    p.oe_n = pdstc_pkg::PDSTC_OE_OFF_N;
    return p;
  endfunction

  // core runs only in the settled on state
  function automatic logic pdstc_is_on(
    input pdstc_pkg::pdstc_pwr_t pwr
  );
    return (pwr == pdstc_pkg::PDSTC_ON);
  endfunction

  // pll starts in wake, so it has a cycle to settle before reset lifts
  function automatic logic pdstc_pll_run(
    input pdstc_pkg::pdstc_pwr_t pwr
  );
    return (pwr != pdstc_pkg::PDSTC_OFF);
  endfunction

  // next power state from the synchronised pin level
  function automatic pdstc_pkg::pdstc_pwr_t pdstc_pwr_next(
    input pdstc_pkg::pdstc_pwr_t cur,
    input logic pin_high
  );
    pdstc_pkg::pdstc_pwr_t nxt;
    nxt = cur;
    unique case (cur)
      pdstc_pkg::PDSTC_OFF: begin
        if (pin_high) begin
          nxt = pdstc_pkg::PDSTC_WAKE;
        end
      end
      pdstc_pkg::PDSTC_WAKE: begin
        // a pin that drops during wake goes straight back to off
        nxt = pin_high ? pdstc_pkg::PDSTC_ON : pdstc_pkg::PDSTC_OFF;
      end
      pdstc_pkg::PDSTC_ON: begin
        if (!pin_high) begin
          nxt = pdstc_pkg::PDSTC_OFF;
        end
      end
      default: nxt = pdstc_pkg::PDSTC_OFF;
    endcase
    return nxt;
  endfunction

  // mode outputs decoded together from the synchronised pins
  typedef struct packed {
    logic st_mode;
    logic clk_sel;
    logic irq_in;
  } pdstc_mode_t;

  function automatic pdstc_mode_t pdstc_mode(
    input logic core_on,
    input pdstc_pkg::pdstc_pins_t p
  );
    pdstc_mode_t m;
    m.st_mode = core_on & p.st_en;
    // outside self-test the select pin is the interrupt input
    m.clk_sel = pdstc_pkg::PDSTC_TEST_CLK_PIXEL;
    if (m.st_mode && p.clk_sel) begin
      m.clk_sel = pdstc_pkg::PDSTC_TEST_CLK_33M;
    end
    m.irq_in = core_on & ~p.st_en & p.clk_sel;
    return m;
  endfunction

  always_comb begin
    pdstc_mode_t mode;
    mode = '0;
    st_d = st_q;
    st_d.pwr = pdstc_pwr_next(st_q.pwr, pins.pwr_n);
    st_d.pll_en = pdstc_pll_run(st_d.pwr);
    st_d.core_rst_n = pdstc_is_on(st_d.pwr);
    st_d.powered = pdstc_is_on(st_d.pwr);

    // mode pins only count once the core is out of reset
    mode = pdstc_mode(st_d.core_rst_n, pins);
    st_d.st_mode = mode.st_mode;
    st_d.clk_sel = mode.clk_sel;
    st_d.irq_in = mode.irq_in;

    // pads stay released until the core leaves reset
    st_d.pad = pdstc_pad_idle();
    if (st_d.core_rst_n) begin
      st_d.pad.out = pdstc_pick(spi_role_sel_i, spi_out_i, fast_gpio_out_i);
      st_d.pad.oe_n = pdstc_pick(spi_role_sel_i, spi_oe_n_i, fast_gpio_oe_n_i);
    end
    st_d.spi_in = pdstc_route(st_d.core_rst_n, spi_role_sel_i, pdstc_pkg::PDSTC_ROLE_SPI, pad_sync);
    st_d.gpio_in = pdstc_route(st_d.core_rst_n, spi_role_sel_i, pdstc_pkg::PDSTC_ROLE_GPIO, pad_sync);
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      st_q.pwr <= pdstc_pkg::PDSTC_OFF;
      st_q.pad.oe_n <= pdstc_pkg::PDSTC_OE_OFF_N;
    end else begin
      st_q <= st_d;
    end
  end

  assign pad_out_o = st_q.pad.out;
  assign pad_oe_n_o = st_q.pad.oe_n;
  assign spi_in_o = st_q.spi_in;
  assign fast_gpio_in_o = st_q.gpio_in;
  assign core_rst_n_o = st_q.core_rst_n;
  assign pll_en_o = st_q.pll_en;
  assign powered_o = st_q.powered;
  assign self_test_mode_o = st_q.st_mode;
  assign test_clk_sel_o = st_q.clk_sel;
  assign external_interrupt_input_o = st_q.irq_in;
endmodule // pdstc_top

// >>> design/pdstc_pkg.sv
// package for power-down and self-test pin control
package pdstc_pkg;
  localparam logic [1:0] PDSTC_SYNC_RST = 2'h0;
  localparam logic PDSTC_TEST_CLK_PIXEL = 1'h0;
  localparam logic PDSTC_TEST_CLK_33M = 1'h1;
  localparam logic PDSTC_ROLE_GPIO = 1'h0;
  localparam logic PDSTC_ROLE_SPI = 1'h1;
  localparam logic [3:0] PDSTC_FGPIO_RST = 4'h0;
  localparam logic [3:0] PDSTC_OE_OFF_N = 4'hF;
  // power state machine, gray coded along off -> wake -> on
  typedef enum logic [1:0] {
    PDSTC_OFF = 2'h0,
    PDSTC_WAKE = 2'h1,
    PDSTC_ON = 2'h3
  } pdstc_pwr_t;
  // synchronised pin levels
  typedef struct packed {
    logic pwr_n;
    logic st_en;
    logic clk_sel;
  } pdstc_pins_t;
  // four shared pins: output value and active-low enable
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } pdstc_pad_t;
endpackage

// >>> design/pdstc_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pdstc_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // async in, synced out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pdstc_sync_st_t;
  pdstc_sync_st_t st_q, st_d;
  always_comb begin
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sync_o = st_q.sync;
endmodule // pdstc_sync

// >>> test/pdstc_host.sv
// host gpio model for the power pin
`timescale 1ns/1ps
module pdstc_host (
  // host side
  input wire logic ok_i,
  input wire logic on_i,
  input wire logic drv_i,
  // device pin
  output logic power_down_n_input_o
);
  // released pin sits at pulldown level
  assign power_down_n_input_o = drv_i & on_i & ok_i;
endmodule // pdstc_host

// >>> test/pdstc_top_sva.sv
// port checker for pdstc_top
`timescale 1ns/1ps
module pdstc_top_sva (
  // clock, reset, pins
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic power_down_n_input_i,
  input wire logic self_test_enable_pin_i,
  input wire logic self_test_clock_select_pin_i,
  // role select and drive values
  input wire logic spi_role_sel_i,
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_n_i,
  input wire logic [3:0] fast_gpio_out_i,
  input wire logic [3:0] fast_gpio_oe_n_i,
  // status
  input wire logic [3:0] pad_out_o,
  input wire logic [3:0] pad_oe_n_o,
  input wire logic core_rst_n_o,
  input wire logic pll_en_o,
  input wire logic powered_o,
  input wire logic self_test_mode_o,
  input wire logic test_clk_sel_o,
  input wire logic external_interrupt_input_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wake_a: assert property ($rose(power_down_n_input_i) |-> ##[2:4] pll_en_o ##1 core_rst_n_o) else $error("wake");
  down_a: assert property ($fell(power_down_n_input_i) |-> ##[2:5] !pll_en_o && !powered_o) else $error("down");
  pads_a: assert property (!pll_en_o |-> pad_oe_n_o == 4'hF) else $error("pads");
  low_a: assert property (!power_down_n_input_i [*6] |-> !pll_en_o) else $error("low");
  hold_a: assert property (core_rst_n_o |-> pll_en_o && powered_o
    && $past(power_down_n_input_i, 3)) else $error("hold");
  mode_a: assert property ((powered_o && self_test_enable_pin_i) [*6] |-> self_test_mode_o) else $error("mode");
  sel_a: assert property ((powered_o && self_test_enable_pin_i && self_test_clock_select_pin_i) [*6]
    |-> test_clk_sel_o) else $error("sel");
  int_a: assert property (external_interrupt_input_o |-> powered_o && !self_test_mode_o && !test_clk_sel_o
    && $past(self_test_clock_select_pin_i, 3) && !$past(self_test_enable_pin_i, 3)) else $error("int");
  role_a: assert property (powered_o |-> pad_out_o == ($past(spi_role_sel_i) ? $past(spi_out_i)
    : $past(fast_gpio_out_i)) && pad_oe_n_o == ($past(spi_role_sel_i) ? $past(spi_oe_n_i)
    : $past(fast_gpio_oe_n_i))) else $error("role");
endmodule // pdstc_top_sva

// >>> test/pdstc_top_test.sv
// testbench for pdstc_top
`timescale 1ns/1ps
module pdstc_top_test;
  logic clock_i = 0, nrst_i = 0, ok = 0, on = 0, drv = 0, en = 0, sel = 1, role = 0, pwr;
  logic [3:0] so = 4'hA, soe = 4'h3, go = 4'h5, goe = 4'hC, pin = 4'h9, po, poe, si, gi;
  logic cr, pll, pd, stm, tcs, ext;
  int failures = 0, n_checks = 0;
  always #4 clock_i = ~clock_i;
  pdstc_host i_host (.ok_i(ok), .on_i(on), .drv_i(drv), .power_down_n_input_o(pwr));
  pdstc_top i_dut (.clock_i, .nrst_i, .power_down_n_input_i(pwr), .self_test_enable_pin_i(en),
    .self_test_clock_select_pin_i(sel), .spi_role_sel_i(role), .spi_out_i(so), .spi_oe_n_i(soe),
    .fast_gpio_out_i(go), .fast_gpio_oe_n_i(goe), .pad_in_i(pin), .pad_out_o(po), .pad_oe_n_o(poe),
    .spi_in_o(si), .fast_gpio_in_o(gi), .core_rst_n_o(cr), .pll_en_o(pll), .powered_o(pd),
    .self_test_mode_o(stm), .test_clk_sel_o(tcs), .external_interrupt_input_o(ext));
  task chk(input logic [3:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task give_verdict;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_off;
    cyc(8);
    chk({pll, pd, stm, ext}, 4'h0);
    chk(poe, 4'hF);
    chk(po, 4'h0);
    chk(si | gi, 4'h0);
  endtask
  task t_on;
    {on, drv} = 2'h3;
    cyc(4);
    chk({pwr, pll, cr}, 4'h0);
    ok = 1;
    cyc(3);
    chk({pll, cr}, 4'h2);
    cyc(1);
    chk({cr, pd}, 4'h3);
  endtask
  task t_mode;
    for (int i = 0; i < 4; i++) begin
      {en, sel} = i[1:0];
      cyc(5);
      chk({stm, tcs, ext}, {1'b0, i[1], i[1] & i[0], !i[1] & i[0]});
    end
  endtask
  task t_role;
    for (int r = 0; r < 2; r++) begin
      role = r[0];
      cyc(4);
      chk(po, r ? 4'hA : 4'h5);
      chk(poe, r ? 4'h3 : 4'hC);
      chk(r ? si : gi, 4'h9);
      chk(r ? gi : si, 4'h0);
    end
  endtask
  task t_down;
    on = 0;
    cyc(5);
    chk({pll, pd, stm}, 4'h0);
    chk(poe, 4'hF);
  endtask
  task t_again;
    on = 1;
    cyc(4);
    chk({cr, pd, stm, tcs}, 4'hF);
  endtask
  initial begin
    cyc(3);
    nrst_i = 1;
    t_off;
    t_on;
    t_mode;
    t_role;
    t_down;
    t_again;
    give_verdict;
  end
  initial begin
    #4000;
    failures++;
    give_verdict;
  end
endmodule // pdstc_top_test
bind pdstc_top pdstc_top_sva i_sva (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .power_down_n_input_i(power_down_n_input_i),
  .self_test_enable_pin_i(self_test_enable_pin_i),
  .self_test_clock_select_pin_i(self_test_clock_select_pin_i),
  .spi_role_sel_i(spi_role_sel_i),
  .spi_out_i(spi_out_i),
  .spi_oe_n_i(spi_oe_n_i),
  .fast_gpio_out_i(fast_gpio_out_i),
  .fast_gpio_oe_n_i(fast_gpio_oe_n_i),
  .pad_out_o(pad_out_o),
  .pad_oe_n_o(pad_oe_n_o),
  .core_rst_n_o(core_rst_n_o),
  .pll_en_o(pll_en_o),
  .powered_o(powered_o),
  .self_test_mode_o(self_test_mode_o),
  .test_clk_sel_o(test_clk_sel_o),
  .external_interrupt_input_o(external_interrupt_input_o)
);
